/* File: core/itoc_pkg.sv */
// Constants, types and register map of the inverse-time overcurrent block
package itoc_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_PICKUP   = 12'h004;
  localparam logic [11:0] REG_TMULT    = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00C;
  localparam logic [11:0] REG_ACCUM    = 12'h010;
  localparam logic [11:0] REG_CHARTIME = 12'h014;
  localparam logic [11:0] TRIP_BASE    = 12'h040;
  localparam logic [11:0] RST_BASE     = 12'h100;
  // Curve tables
  localparam logic [9:0]  TAB_DEPTH = 10'h014;
  localparam logic [4:0]  TAB_LAST  = 5'h13;
  localparam logic [31:0] TAB_RESET = 32'hFFFFFFFF;
  localparam logic [15:0] VAL_INF   = 16'hFFFF;
  localparam logic [15:0] UNITY_Q   = 16'h0100;
  // Pickup, dropout and immediate-reset ratios
  localparam logic [23:0] PU_NUM = 24'h00000B;
  localparam logic [23:0] PU_DEN = 24'h00000A;
  localparam logic [23:0] DO_NUM = 24'h000013;
  localparam logic [23:0] DO_DEN = 24'h000014;
  localparam logic [23:0] QR_NUM = 24'h000001;
  localparam logic [23:0] QR_DEN = 24'h000014;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_PERIOD_NS  = 1000000;
  localparam int unsigned TICK_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [8:0]  MC_STRETCH_MS = 9'h12C;
  localparam logic [23:0] ACC_MAX = 24'hFFFFFF;
  localparam logic [4:0]  DIV_LAST = 5'h1F;
  // Reset values
  localparam logic [15:0] PICKUP_RST = 16'h0100;
  localparam logic [15:0] TMULT_RST  = 16'h01F4;
  // Characteristic and manual-close selections
  localparam logic [1:0] CH_DIAL     = 2'h0;
  localparam logic [1:0] CH_USER_PU  = 2'h1;
  localparam logic [1:0] CH_USER_RST = 2'h2;
  localparam logic [1:0] MC_HS   = 2'h0;
  localparam logic [1:0] MC_LS   = 2'h1;
  localparam logic [1:0] MC_INV  = 2'h2;
  typedef struct packed {
    logic       hs_sup;
    logic [1:0] mc_sel;
    logic       disk;
    logic [1:0] charac;
    logic       en;
  } itoc_ctrl_t;
  localparam itoc_ctrl_t CTRL_RST = 7'h09;
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_DIVM, ENG_SCAN, ENG_PICK, ENG_DIVI, ENG_DONE
  } itoc_eng_t;
endpackage : itoc_pkg

/* File: core/itoc_top.sv */
// Inverse-time overcurrent decision logic with APB register file
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1: Pickup asserts when current reaches 110 percent of pickup setting.
// RULE2: Between 100 and 110 percent pickup may or may not assert.
// RULE3: Picked-up element drops out at 95 percent of pickup setting.
// RULE4: Infinite time multiplier still picks up but never trips.
// RULE5: Disk emulation resets gradually along the reset characteristic.
// RULE6: Manual-close impulse stretched so bypass stays active 300 ms.
// RULE7: Four-way selection picks high-set, low-set, inverse-time or none.
// RULE8: Bypass hits only the selected element, tripping at once if picked up.
// RULE9: Control switch feeds manual close onto its input.
// RULE10: Reclose-dependent mode inhibits high-set while reclosing blocked.
// RULE11: Reclosing equipment presents its enabled status on an input.
// RULE12: Trip table holds at most 20 current/time pairs.
// RULE13: Table currents scale by pickup, table times by time multiplier.
// RULE14: Points are ordered by ascending current whatever the entry order.
// RULE15: Ten pairs suffice; pairs with infinite current are unused.
// RULE16: Table times reset to infinity so no trip results.
// RULE17: Below smallest current, time of smallest point is used.
// RULE18: Above largest current, time of largest point is used.
// RULE19: Reset table used only with user pickup-and-reset characteristic.
// RULE20: Above largest reset current, its reset time is held.
// RULE21: Below smallest reset current, its reset time is held.
// RULE22: Current under 0.05 of pickup resets immediately.
// RULE23: Between neighbouring points time is linearly interpolated.
// RULE24: Trip when accumulated time reaches curve time; dropout cancels.
module itoc_top
  import itoc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] meas_current,
  input  wire logic        manual_close_in,
  input  wire logic        reclose_enabled_in,
  output logic             ito_pickup,
  output logic             ito_trip,
  output logic             hs_bypass,
  output logic             ls_bypass,
  output logic             hs_enable
);
  itoc_ctrl_t  ctrl_ff;
  logic [15:0] pickup_set_ff, tmult_ff;
  logic [31:0] trip_tab_ff [20];
  logic [31:0] rst_tab_ff [20];
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff;
  logic [14:0] tick_cnt_ff;
  logic        tick_ff;
  logic        pickup_ff, trip_ff, nxt_trip;
  logic [23:0] accum_ff, rst_cnt_ff, char_ms_ff;
  logic        char_inf_ff, char_pu_ff;
  logic [8:0]  mc_cnt_ff;
  logic        mc_active_ff, hs_bypass_ff, ls_bypass_ff, inv_bypass_ff;
  logic        hs_enable_ff;
  itoc_eng_t   eng_st_ff;
  logic        eng_pu_ff, eng_rst_ff;
  logic [4:0]  idx_ff, div_cnt_ff;
  logic [15:0] m_ff, eng_t_ff, lo_c_ff, lo_t_ff, hi_c_ff, hi_t_ff;
  logic        have_lo_ff, have_hi_ff;
  logic [16:0] div_rem_ff;
  logic [31:0] div_quo_ff;
  logic [15:0] div_den_ff;
  // Comparator and datapath wires
  logic [23:0] meas_w, set_w;
  logic        pu_hi, do_lo, quick_rst, gradual;
  logic [16:0] div_shift, div_rem_nxt;
  logic        div_fit;
  logic [31:0] div_quo_nxt, prod, ent;
  logic        slope_up;
  logic [15:0] dt, dm;
  logic [11:0] trip_off, rst_off;
  logic        trip_hit, rst_hit, wr_go;
  logic [31:0] rd_mux;
  logic        rd_ok, ro_reg;

  assign meas_w = {8'h00, meas_current};
  assign set_w  = {8'h00, pickup_set_ff};
  // Level comparisons against the pickup setting
  assign pu_hi     = (meas_w * PU_DEN) >= (set_w * PU_NUM); // RULE1 RULE2
  assign do_lo     = (meas_w * DO_DEN) <= (set_w * DO_NUM); // RULE3
  assign quick_rst = (meas_w * QR_DEN) <  (set_w * QR_NUM); // RULE22
  assign gradual = ((ctrl_ff.charac == CH_DIAL) && ctrl_ff.disk) ||
                   (ctrl_ff.charac == CH_USER_RST);

  // APB decode
  assign trip_off = paddr - TRIP_BASE;
  assign rst_off  = paddr - RST_BASE;
  assign trip_hit = (paddr >= TRIP_BASE) && (trip_off[11:2] < TAB_DEPTH) &&
                    (paddr[1:0] == 2'h0); // RULE12
  assign rst_hit  = (paddr >= RST_BASE) && (rst_off[11:2] < TAB_DEPTH) &&
                    (paddr[1:0] == 2'h0);
  assign wr_go = psel && penable && pready_ff && pwrite && !pslverr_ff;

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    ro_reg = 1'b0;
    if (trip_hit) begin
      rd_mux = trip_tab_ff[trip_off[6:2]];
    end else if (rst_hit) begin
      rd_mux = rst_tab_ff[rst_off[6:2]];
    end else begin
      case (paddr)
        REG_CTRL:   rd_mux = {25'h0000000, ctrl_ff};
        REG_PICKUP: rd_mux = {16'h0000, pickup_set_ff};
        REG_TMULT:  rd_mux = {16'h0000, tmult_ff};
        REG_STATUS: begin
          ro_reg = 1'b1;
          rd_mux = {26'h0000000, (!pickup_ff && accum_ff != 24'h000000),
                    char_inf_ff, hs_enable_ff, mc_active_ff, trip_ff, pickup_ff};
        end
        REG_ACCUM: begin
          ro_reg = 1'b1;
          rd_mux = {8'h00, accum_ff};
        end
        REG_CHARTIME: begin
          ro_reg = 1'b1;
          rd_mux = {char_inf_ff, 7'h00, char_ms_ff};
        end
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Bus answer, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && (!rd_ok || (pwrite && ro_reg));
      if (psel && !penable && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Setting registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff       <= CTRL_RST;
      pickup_set_ff <= PICKUP_RST;
      tmult_ff      <= TMULT_RST;
    end else if (wr_go) begin
      if (paddr == REG_CTRL) ctrl_ff <= itoc_ctrl_t'(pwdata[6:0]);
      if (paddr == REG_PICKUP) pickup_set_ff <= pwdata[15:0];
      if (paddr == REG_TMULT) tmult_ff <= pwdata[15:0];
    end
  end

  // Curve tables, times infinite after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 20; i++) begin
        trip_tab_ff[i] <= TAB_RESET; // RULE16
        rst_tab_ff[i]  <= TAB_RESET;
      end
    end else if (wr_go) begin
      if (trip_hit) trip_tab_ff[trip_off[6:2]] <= pwdata;
      if (rst_hit) rst_tab_ff[rst_off[6:2]] <= pwdata;
    end
  end

  // Millisecond tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 15'h0000;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == 15'(TICK_CYCLES - 1));
      if (tick_cnt_ff == 15'(TICK_CYCLES - 1)) tick_cnt_ff <= 15'h0000;
      else tick_cnt_ff <= tick_cnt_ff + 15'h0001;
    end
  end

  // Pickup with hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pickup_ff <= 1'b0;
    else if (!ctrl_ff.en) pickup_ff <= 1'b0;
    else if (!pickup_ff && pu_hi) pickup_ff <= 1'b1; // RULE1
    else if (pickup_ff && do_lo) pickup_ff <= 1'b0; // RULE3
  end

  // Restoring divider step
  assign div_shift   = {div_rem_ff[15:0], div_quo_ff[31]};
  assign div_fit     = div_shift >= {1'b0, div_den_ff};
  assign div_rem_nxt = div_fit ? div_shift - {1'b0, div_den_ff} : div_shift;
  assign div_quo_nxt = {div_quo_ff[30:0], div_fit};
  // Table entry, interpolation terms and time scaling
  assign ent      = eng_rst_ff ? rst_tab_ff[idx_ff] : trip_tab_ff[idx_ff];
  assign slope_up = hi_t_ff >= lo_t_ff;
  assign dt = slope_up ? hi_t_ff - lo_t_ff : lo_t_ff - hi_t_ff;
  assign dm = m_ff - lo_c_ff;
  assign prod = {16'h0000, eng_t_ff} * {16'h0000, tmult_ff}; // RULE13

  // Characteristic engine: multiple of pickup, neighbour search, interpolation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_st_ff <= ENG_IDLE;
      {eng_pu_ff, eng_rst_ff, have_lo_ff, have_hi_ff} <= 4'h0;
      {idx_ff, div_cnt_ff} <= 10'h000;
      {m_ff, lo_c_ff, lo_t_ff, hi_c_ff, hi_t_ff} <= 80'h0;
      eng_t_ff    <= VAL_INF;
      div_rem_ff  <= 17'h00000;
      div_quo_ff  <= 32'h00000000;
      div_den_ff  <= 16'h0000;
      char_ms_ff  <= 24'h000000;
      char_inf_ff <= 1'b1;
      char_pu_ff  <= 1'b0;
    end else begin
      case (eng_st_ff)
        ENG_IDLE: begin
          eng_pu_ff  <= pickup_ff;
          eng_rst_ff <= !pickup_ff && (ctrl_ff.charac == CH_USER_RST); // RULE19
          div_rem_ff <= 17'h00000;
          div_cnt_ff <= 5'h00;
          div_quo_ff <= {8'h00, meas_current, 8'h00}; // RULE13
          div_den_ff <= pickup_set_ff;
          if (ctrl_ff.charac == CH_DIAL) begin
            eng_t_ff  <= UNITY_Q;
            eng_st_ff <= ENG_DONE;
          end else begin
            eng_st_ff <= ENG_DIVM;
          end
        end
        ENG_DIVM, ENG_DIVI: begin
          div_rem_ff <= div_rem_nxt;
          div_quo_ff <= div_quo_nxt;
          div_cnt_ff <= div_cnt_ff + 5'h01;
          if (div_cnt_ff == DIV_LAST && eng_st_ff == ENG_DIVM) begin
            m_ff <= (div_quo_nxt[31:16] != 16'h0000) ? VAL_INF : div_quo_nxt[15:0];
            idx_ff     <= 5'h00;
            have_lo_ff <= 1'b0;
            have_hi_ff <= 1'b0;
            eng_st_ff  <= ENG_SCAN;
          end else if (div_cnt_ff == DIV_LAST) begin
            // RULE23
            eng_t_ff  <= slope_up ? lo_t_ff + div_quo_nxt[15:0] : lo_t_ff - div_quo_nxt[15:0];
            eng_st_ff <= ENG_DONE;
          end
        end
        ENG_SCAN: begin
          // Closest points either side, independent of entry order
          if (ent[15:0] != VAL_INF) begin // RULE15
            if (ent[15:0] <= m_ff && (!have_lo_ff || ent[15:0] >= lo_c_ff)) begin // RULE14
              lo_c_ff    <= ent[15:0];
              lo_t_ff    <= ent[31:16];
              have_lo_ff <= 1'b1;
            end
            if (ent[15:0] >= m_ff && (!have_hi_ff || ent[15:0] < hi_c_ff)) begin // RULE14
              hi_c_ff    <= ent[15:0];
              hi_t_ff    <= ent[31:16];
              have_hi_ff <= 1'b1;
            end
          end
          idx_ff <= idx_ff + 5'h01;
          if (idx_ff == TAB_LAST) eng_st_ff <= ENG_PICK;
        end
        ENG_PICK: begin
          eng_st_ff <= ENG_DONE;
          if (!have_lo_ff && !have_hi_ff) begin
            eng_t_ff <= VAL_INF;
          end else if (!have_lo_ff) begin
            eng_t_ff <= hi_t_ff; // RULE17 RULE21
          end else if (!have_hi_ff || lo_c_ff == hi_c_ff) begin
            eng_t_ff <= lo_t_ff; // RULE18 RULE20
          end else if (lo_t_ff == VAL_INF || hi_t_ff == VAL_INF) begin
            eng_t_ff <= VAL_INF;
          end else begin
            div_rem_ff <= 17'h00000;
            div_cnt_ff <= 5'h00;
            div_quo_ff <= {16'h0000, dt} * {16'h0000, dm}; // RULE23
            div_den_ff <= hi_c_ff - lo_c_ff;
            eng_st_ff  <= ENG_DIVI;
          end
        end
        ENG_DONE: begin
          char_inf_ff <= (eng_t_ff == VAL_INF) || (tmult_ff == VAL_INF); // RULE4 RULE16
          char_ms_ff  <= prod[31:8];
          char_pu_ff  <= eng_pu_ff;
          eng_st_ff   <= ENG_IDLE;
        end
        default: eng_st_ff <= ENG_IDLE;
      endcase
    end
  end

  // Accumulated pickup time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) accum_ff <= 24'h000000;
    else if (!ctrl_ff.en || quick_rst) accum_ff <= 24'h000000; // RULE22
    else if (pickup_ff) begin
      if (tick_ff && accum_ff != ACC_MAX) accum_ff <= accum_ff + 24'h000001; // RULE24
    end else if (!gradual) accum_ff <= 24'h000000; // RULE24
    else if (!char_pu_ff && !char_inf_ff && rst_cnt_ff >= char_ms_ff) begin
      accum_ff <= 24'h000000; // RULE5
    end
  end

  // Reset timing while dropped out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_cnt_ff <= 24'h000000;
    else if (pickup_ff || !gradual || accum_ff == 24'h000000) rst_cnt_ff <= 24'h000000;
    else if (tick_ff && rst_cnt_ff != ACC_MAX) rst_cnt_ff <= rst_cnt_ff + 24'h000001; // RULE5
  end

  // Trip decision
  assign nxt_trip = ctrl_ff.en && pickup_ff && char_pu_ff && !char_inf_ff &&
                    (accum_ff >= char_ms_ff || inv_bypass_ff); // RULE24 RULE8 RULE4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trip_ff <= 1'b0;
    else trip_ff <= nxt_trip;
  end

  // Manual-close stretch and bypass selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_ff     <= 9'h000;
      mc_active_ff  <= 1'b0;
      hs_bypass_ff  <= 1'b0;
      ls_bypass_ff  <= 1'b0;
      inv_bypass_ff <= 1'b0;
    end else begin
      if (manual_close_in) mc_cnt_ff <= MC_STRETCH_MS; // RULE6 RULE9
      else if (tick_ff && mc_cnt_ff != 9'h000) mc_cnt_ff <= mc_cnt_ff - 9'h001;
      mc_active_ff  <= manual_close_in || (mc_cnt_ff != 9'h000); // RULE6
      hs_bypass_ff  <= mc_active_ff && (ctrl_ff.mc_sel == MC_HS); // RULE7
      ls_bypass_ff  <= mc_active_ff && (ctrl_ff.mc_sel == MC_LS); // RULE7
      inv_bypass_ff <= mc_active_ff && (ctrl_ff.mc_sel == MC_INV); // RULE7 RULE8
    end
  end

  // High-set supervision by reclosing status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hs_enable_ff <= 1'b1;
    else hs_enable_ff <= !ctrl_ff.hs_sup || reclose_enabled_in; // RULE10 RULE11
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign ito_pickup = pickup_ff;
  assign ito_trip   = trip_ff;
  assign hs_bypass  = hs_bypass_ff;
  assign ls_bypass  = ls_bypass_ff;
  assign hs_enable  = hs_enable_ff;

  // Checks on the decision logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pickup_high: assert property (ctrl_ff.en && pu_hi |=> pickup_ff) // RULE1
    else $error("no pickup at 110 percent");
  chk_no_low_pu: assert property (!pickup_ff && !pu_hi |=> !pickup_ff) // RULE2
    else $error("pickup below threshold");
  chk_dropout_low: assert property (pickup_ff && do_lo |=> !pickup_ff) // RULE3
    else $error("no dropout at 95 percent");
  chk_inf_no_trip: assert property (char_inf_ff |=> !trip_ff) // RULE4
    else $error("trip with infinite time");
  chk_mc_stretch: assert property ($fell(manual_close_in) |=> mc_active_ff[*8]) // RULE6
    else $error("manual close not stretched");
  chk_mc_select: assert property (mc_active_ff && ctrl_ff.mc_sel == MC_HS
    |=> hs_bypass_ff && !ls_bypass_ff && !inv_bypass_ff) // RULE7
    else $error("wrong bypass element");
  chk_one_bypass: assert property ($onehot0({hs_bypass_ff, ls_bypass_ff, inv_bypass_ff})) // RULE8
    else $error("more than one bypass");
  chk_hs_superv: assert property (ctrl_ff.hs_sup && !reclose_enabled_in
    |=> !hs_enable_ff) // RULE10
    else $error("high-set not inhibited");
  chk_quick_reset: assert property (quick_rst |=> accum_ff == 24'h000000) // RULE22
    else $error("no immediate reset");
  chk_trip_time: assert property (ctrl_ff.en && pickup_ff && char_pu_ff && !char_inf_ff &&
    accum_ff >= char_ms_ff |=> trip_ff) // RULE24
    else $error("trip missing at curve time");
  chk_drop_cancel: assert property (!pickup_ff |=> !trip_ff) // RULE24
    else $error("trip without pickup");
  cov_trip: cover property ($rose(trip_ff));
  cov_mc_trip: cover property (inv_bypass_ff && $rose(trip_ff));
  cov_grad_reset: cover property (!pickup_ff && rst_cnt_ff != 24'h000000 ##1
                                  accum_ff == 24'h000000);
  cov_hs_block: cover property ($fell(hs_enable_ff));
endmodule : itoc_top
`default_nettype wire

/* File: test/itoc_switchgear_model.sv */
// Far-side model: control switch and automatic reclosing equipment
`timescale 1ns/10ps
`default_nettype none
module itoc_switchgear_model #(
  parameter logic [7:0] PULSE_CYCLES = 8'h02
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic close_cmd,
  input  wire logic recl_cmd,
  output logic      manual_close_in,
  output logic      reclose_enabled_in
);
  logic [7:0] pulse_cnt_ff;
  // Switch impulse lasts a few cycles, then the input goes back low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_ff    <= 8'h00;
      manual_close_in <= 1'b0;
    end else begin
      pulse_cnt_ff    <= close_cmd ? PULSE_CYCLES : pulse_cnt_ff - {7'h00, |pulse_cnt_ff};
      manual_close_in <= close_cmd | (pulse_cnt_ff > 8'h01);
    end
  end
  // Reclosing-enabled status presented as a steady level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reclose_enabled_in <= 1'b0;
    end else begin
      reclose_enabled_in <= recl_cmd;
    end
  end
endmodule // itoc_switchgear_model
`default_nettype wire

/* File: test/itoc_top_bench.sv */
// Self-checking bench for the inverse-time overcurrent block
`timescale 1ns/10ps
`default_nettype none
module itoc_top_bench;
  import itoc_pkg::*;
  localparam int TICK = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        close_cmd, recl_cmd, mc_in, recl_in;
  logic        ito_pickup, ito_trip, hs_bypass, ls_bypass, hs_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] meas;
  int          n_mismatch, n_compared;

  itoc_top #(.TICK_CYCLES(TICK)) itoc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_current(meas), .manual_close_in(mc_in), .reclose_enabled_in(recl_in),
    .ito_pickup(ito_pickup), .ito_trip(ito_trip), .hs_bypass(hs_bypass),
    .ls_bypass(ls_bypass), .hs_enable(hs_enable));
  itoc_switchgear_model itoc_switchgear_model_inst (
    .pclk(pclk), .presetn(presetn), .close_cmd(close_cmd), .recl_cmd(recl_cmd),
    .manual_close_in(mc_in), .reclose_enabled_in(recl_in));

  // Clock at 20 MHz
  always #25 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; waits for pready without a bound and checks it came one cycle after penable
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check("pready wait", 32'h1, n);
    rq = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xerr);
    logic e;
    apb(1'b1, a, d, q, e);
    check("write error", {31'h0, xerr}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, exp, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic setm(input logic [15:0] v);
    @(posedge pclk);
    meas <= v;
  endtask

  // Reset values, refused accesses, table size
  task automatic t_regs();
    rd(REG_CTRL, 32'h00000009, "ctrl reset");
    rd(REG_PICKUP, 32'h00000100, "pickup reset");
    rd(REG_TMULT, 32'h000001F4, "tmult reset");
    rd(TRIP_BASE + 12'h04C, 32'hFFFFFFFF, "last trip word");
    rd(RST_BASE, 32'hFFFFFFFF, "reset word");
    wr(TRIP_BASE + 12'h050, 32'h0, 1'b1);
    wr(REG_STATUS, 32'h0, 1'b1);
    wr(12'h200, 32'h0, 1'b1);
    $display("test regs done");
  endtask
  // Pickup, hysteresis and infinite multiplier
  task automatic t_pickup();
    wr(REG_TMULT, 32'h0000FFFF, 1'b0);
    setm(16'h011A);
    cyc(4);
    check("pickup at 110", 32'h1, {31'h0, ito_pickup});
    cyc(20 * TICK);
    check("no trip infinite", 32'h0, {31'h0, ito_trip});
    setm(16'h0104);
    cyc(4);
    check("held in band", 32'h1, {31'h0, ito_pickup});
    setm(16'h00F3);
    cyc(4);
    check("dropout at 95", 32'h0, {31'h0, ito_pickup});
    setm(16'h0000);
    $display("test pickup done");
  endtask
  // Trip after curve time, cancel and immediate reset
  task automatic t_trip();
    wr(REG_CTRL, 32'h00000031, 1'b0);
    wr(REG_TMULT, 32'h00000005, 1'b0);
    setm(16'h012C);
    cyc(3 * TICK);
    check("no early trip", 32'h0, {31'h0, ito_trip});
    cyc(4 * TICK);
    check("trip", 32'h1, {31'h0, ito_trip});
    setm(16'h0000);
    cyc(4);
    check("trip cancel", 32'h0, {31'h0, ito_trip});
    rd(REG_ACCUM, 32'h0, "accum cleared");
    $display("test trip done");
  endtask
  // Disk emulation holds the accumulator, then resets along the curve
  task automatic t_disk();
    wr(REG_CTRL, 32'h00000039, 1'b0);
    wr(REG_TMULT, 32'h00000014, 1'b0);
    setm(16'h012C);
    cyc(4 * TICK);
    setm(16'h00C8);
    cyc(4);
    rd(REG_STATUS, 32'h00000028, "resetting status");
    rd(REG_ACCUM, 32'h00000004, "accum held");
    cyc(25 * TICK);
    rd(REG_ACCUM, 32'h0, "accum after reset");
    setm(16'h0000);
    $display("test disk done");
  endtask
  // Manual-close selection and stretch
  task automatic t_manual();
    wr(REG_TMULT, 32'h000003E8, 1'b0);
    setm(16'h012C);
    for (int s = 0; s < 4; s++) begin
      wr(REG_CTRL, 32'h00000001 | (s << 4), 1'b0);
      @(posedge pclk);
      close_cmd <= 1'b1;
      @(posedge pclk);
      close_cmd <= 1'b0;
      cyc(6);
      check("hs bypass", {31'h0, s == 0}, {31'h0, hs_bypass});
      check("ls bypass", {31'h0, s == 1}, {31'h0, ls_bypass});
      if (s < 3) check("bypass trip", {31'h0, s == 2}, {31'h0, ito_trip});
    end
    setm(16'h0000);
    cyc(310 * TICK);
    wr(REG_CTRL, 32'h00000001, 1'b0);
    close_cmd <= 1'b1;
    @(posedge pclk);
    close_cmd <= 1'b0;
    cyc(290 * TICK);
    check("stretch active", 32'h1, {31'h0, hs_bypass});
    cyc(13 * TICK);
    check("stretch over", 32'h0, {31'h0, hs_bypass});
    $display("test manual done");
  endtask
  // High-set supervision by reclosing status
  task automatic t_hs();
    wr(REG_CTRL, 32'h00000041, 1'b0);
    cyc(4);
    check("hs blocked", 32'h0, {31'h0, hs_enable});
    recl_cmd <= 1'b1;
    cyc(4);
    check("hs with reclose", 32'h1, {31'h0, hs_enable});
    recl_cmd <= 1'b0;
    wr(REG_CTRL, 32'h00000001, 1'b0);
    cyc(4);
    check("hs always", 32'h1, {31'h0, hs_enable});
    $display("test hs done");
  endtask
  // User table: default infinity, clamps and interpolation
  task automatic t_table();
    wr(REG_CTRL, 32'h00000033, 1'b0);
    wr(REG_TMULT, 32'h0000000A, 1'b0);
    setm(16'h0500);
    cyc(300);
    rd(REG_CHARTIME, 32'h800009FF, "default infinite");
    wr(TRIP_BASE, 32'h01000400, 1'b0);
    wr(TRIP_BASE + 12'h004, 32'h03000200, 1'b0);
    cyc(300);
    rd(REG_CHARTIME, 32'h0000000A, "above largest");
    setm(16'h0300);
    cyc(300);
    rd(REG_CHARTIME, 32'h00000014, "interpolated");
    setm(16'h012C);
    cyc(300);
    rd(REG_CHARTIME, 32'h0000001E, "below smallest");
    wr(RST_BASE, 32'h02000080, 1'b0);
    wr(RST_BASE + 12'h004, 32'h030000A0, 1'b0);
    wr(REG_CTRL, 32'h00000035, 1'b0);
    setm(16'h00C8);
    cyc(300);
    rd(REG_CHARTIME, 32'h0000001E, "reset above largest");
    setm(16'h0060);
    cyc(300);
    rd(REG_CHARTIME, 32'h00000014, "reset below smallest");
    setm(16'h0000);
    $display("test table done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #5000000;
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, close_cmd, recl_cmd} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    meas = 16'h0000;
    n_mismatch = 0;
    n_compared = 0;
    cyc(16);
    presetn <= 1'b1;
    t_regs();
    t_pickup();
    t_trip();
    t_disk();
    t_manual();
    t_hs();
    t_table();
    report_and_stop();
  end
endmodule // itoc_top_bench
`default_nettype wire
